//--- core/pbc_pkg.sv
package pbc_pkg;
    // core clock rate, used to turn times into cycle counts
    localparam int CLK_MHZ = 25;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TOT_LIM = 8'h04;
    localparam logic [7:0] ADDR_ERR_LIM = 8'h08;
    localparam logic [7:0] ADDR_BIT_CNT = 8'h0C;
    localparam logic [7:0] ADDR_ERR_CNT = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // control register fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_CLK_POL = 3;
    localparam int CTRL_DATA_INV = 4;
    localparam int CTRL_GATE_EN = 5;
    localparam int CTRL_GATE_POL = 6;
    localparam int CTRL_INTEG = 7;
    localparam int CTRL_RUN = 8;
    localparam int CTRL_W = 9;

    // status register fields
    localparam int STS_DONE = 0;
    localparam int STS_BY_TOT = 1;
    localparam int STS_BY_ERR = 2;
    localparam int STS_LOCKED = 3;
    localparam int STS_CLK_ACT = 4;
    localparam int STS_DATA_ACT = 5;
    localparam int STS_SLIP = 6;

    // values after reset: degree 9, rising clock edge, stopped
    localparam logic [8:0] CTRL_RESET = 9'h008;
    localparam logic [31:0] TOT_LIM_RESET = 32'h000F_4240;
    localparam logic [31:0] ERR_LIM_RESET = 32'h0000_0064;

    // activity window: a line is active if it toggled within this time
    localparam int ACT_WIN_NS = 10000;
    localparam int ACT_WIN_CYC = ACT_WIN_NS * CLK_MHZ / 1000;
    localparam logic [7:0] ACT_WIN_LOAD = 8'(ACT_WIN_CYC);

    // polynomial selection codes
    localparam logic [2:0] PRBS_DEGREE9 = 3'h0;
    localparam logic [2:0] PRBS_DEGREE11 = 3'h1;
    localparam logic [2:0] PRBS_DEGREE15 = 3'h2;
    localparam logic [2:0] PRBS_DEGREE16 = 3'h3;
    localparam logic [2:0] PRBS_DEGREE20 = 3'h4;
    localparam logic [2:0] PRBS_DEGREE21 = 3'h5;
    localparam logic [2:0] PRBS_DEGREE23 = 3'h6;

    // feedback tap masks (bit k-1 for tap k), degrees, output inversion
    localparam logic [22:0] PRBS_TAPS [7] = '{23'h000108, 23'h000402,
        23'h004001, 23'h008016, 23'h080004, 23'h100002, 23'h400010};
    localparam logic [4:0] PRBS_DEG [7] = '{5'h09, 5'h0B, 5'h0F, 5'h10,
        5'h14, 5'h15, 5'h17};
    localparam logic [6:0] PRBS_INV = 7'h44;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} pbc_state_type;
endpackage

//--- core/pbc_lfsr_if.sv
`timescale 1ns/100ps
interface pbc_lfsr_if;
    logic clear;
    logic shift;
    logic rx_bit;
    logic [2:0] sel;
    logic pred_bit;
    logic locked;
    logic miss;
    modport ctl(output clear, output shift, output rx_bit, output sel,
        input pred_bit, input locked, input miss);
    modport lfsr(input clear, input shift, input rx_bit, input sel,
        output pred_bit, output locked, output miss);
endinterface

//--- core/pbc_prbs_lfsr.sv
`timescale 1ns/100ps
module pbc_prbs_lfsr (
    input wire logic core_clk,
    input wire logic reset,
    pbc_lfsr_if.lfsr lf
);
    logic [22:0] sr_q;
    logic [4:0] fill_q;
    logic lock_q;
    logic [2:0] idx;
    logic fb;

    // unused code 7 falls back to degree 9
    always_comb begin
        idx = (lf.sel > pbc_pkg::PRBS_DEGREE23) ? pbc_pkg::PRBS_DEGREE9 : lf.sel;
        fb = ^(sr_q & pbc_pkg::PRBS_TAPS[idx]);
    end

    assign lf.pred_bit = fb;
    assign lf.locked = lock_q;
    assign lf.miss = lock_q & (lf.rx_bit != fb);

    // one register: filled from the line, then running on its own feedback
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sr_q <= 23'h000000;
        end else if (lf.shift) begin
            sr_q <= {sr_q[21:0], lock_q ? fb : lf.rx_bit};
        end
    end

    // lock after exactly degree bits, never more than 23 so within 24
    always_ff @(posedge core_clk) begin
        if (reset || lf.clear) begin
            fill_q <= 5'h00;
            lock_q <= 1'h0;
        end else if (lf.shift && !lock_q) begin
            if (fill_q == pbc_pkg::PRBS_DEG[idx] - 5'h01) begin
                lock_q <= 1'h1;
            end else begin
                fill_q <= fill_q + 5'h01;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_fill_then_lock;
        lf.shift && !lf.clear && !lock_q && fill_q == pbc_pkg::PRBS_DEG[idx] - 5'h01 |=> lock_q;
    endproperty
    a_fill_then_lock: assert property (p_fill_then_lock) else $error("no lock after fill");

    property p_clear_unlocks;
        lf.clear |=> !lock_q && fill_q == 5'h00;
    endproperty
    a_clear_unlocks: assert property (p_clear_unlocks) else $error("clear left lock");

    property p_self_feed;
        lf.shift && lock_q && !lf.clear |=> sr_q[0] == $past(fb);
    endproperty
    a_self_feed: assert property (p_self_feed) else $error("locked shift took line bit");
endmodule

//--- core/pbc_checker.sv
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
// What this block does
// - without integration, a break in the sequence keeps lock; about half of the later bits count as errors
// - integrating mode is chosen by setting; restart input then governs halt and start
// - restart input at 1 holds measurement in reset; at 0 measuring runs
// - bits marked non-evaluated by the valid gate are neither checked nor counted
// - integrating mode accumulates counts over restart intervals until a limit is reached
// - one feedback shift register generates and checks; period is 2^n minus 1
// - selectable degree/taps 9/4, 11/2, 15/1, 16/5,3,2, 20/3, 21/2, 23/5
// - degree 15 and 23 outputs are inverted automatically; others are not
// - separate 32-bit counters for evaluated bits and error bits
// - measurement ends when evaluated bits reach the total-bit limit
// - measurement ends when error count reaches the error-bit limit
// - both limits act together; result shows which one ended it
// - next measurement waits until the previous result is queried
// - after restart, lock is regained within 24 data bits
// - a result near half errors is flagged discarded and rerun on the query
// - activity indication for clock and data lines shows toggling
// - gate polarity high evaluates bits only while gate is 1; low inverts that
// - register fills from the line unchecked, then self-feeds and compares each bit
// - clock and data polarity each configurable
module pbc_checker (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic bit_clk_in,
    input wire logic data_in,
    input wire logic data_valid_gate,
    input wire logic measure_restart_in,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    // synchroniser stages: bit 0 clock, 1 data, 2 gate, 3 restart
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [1:0] line_d_q;
    logic [1:0] act;

    logic [8:0] ctrl_q;
    logic [31:0] tot_lim_q;
    logic [31:0] err_lim_q;
    logic [31:0] bit_cnt_q;
    logic [31:0] err_cnt_q;
    logic by_tot_q;
    logic by_err_q;
    logic slip_q;
    pbc_pkg::pbc_state_type st_q;

    logic [2:0] sel;
    logic bit_stb;
    logic rx_raw;
    logic valid;
    logic hold_now;
    logic query;
    logic start;
    logic cnt_en;
    logic [31:0] bit_nx;
    logic [31:0] err_nx;
    logic end_tot;
    logic end_err;
    logic slip_now;
    logic [31:0] status;

    pbc_lfsr_if lf ();

    pbc_prbs_lfsr u_lfsr (
        .core_clk(core_clk),
        .reset(reset),
        .lf(lf.lfsr)
    );

    // two flops on each of the four line inputs before any logic looks at them
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {measure_restart_in, data_valid_gate, data_in, bit_clk_in};
            sync2_q <= sync1_q;
        end
    end

    // third stage for clock and data, only used for edge and activity detection
    always_ff @(posedge core_clk) begin
        if (reset) begin
            line_d_q <= 2'h0;
        end else begin
            line_d_q <= sync2_q[1:0];
        end
    end

    // per-line activity: retriggered by every toggle, decays over the window
    for (genvar g = 0; g < 2; g++) begin : g_act
        logic [7:0] act_cnt_q;
        always_ff @(posedge core_clk) begin
            if (reset) begin
                act_cnt_q <= 8'h00;
            end else if (sync2_q[g] != line_d_q[g]) begin
                act_cnt_q <= pbc_pkg::ACT_WIN_LOAD;
            end else if (act_cnt_q != 8'h00) begin
                act_cnt_q <= act_cnt_q - 8'h01;
            end
        end
        assign act[g] = act_cnt_q != 8'h00;
    end

    // decoded configuration and line conditions at each active bit edge
    always_comb begin
        sel = ctrl_q[pbc_pkg::CTRL_SEL_LSB +: 3];
        // one pulse per active edge of the selected polarity
        bit_stb = (sync2_q[0] != line_d_q[0]) && (sync2_q[0] == ctrl_q[pbc_pkg::CTRL_CLK_POL]);
        // undo line polarity and the standard's output inversion
        rx_raw = sync2_q[1] ^ ctrl_q[pbc_pkg::CTRL_DATA_INV]
            ^ ((sel <= pbc_pkg::PRBS_DEGREE23) && pbc_pkg::PRBS_INV[sel]);
        valid = !ctrl_q[pbc_pkg::CTRL_GATE_EN]
            || (sync2_q[2] == ctrl_q[pbc_pkg::CTRL_GATE_POL]);
        // restart only matters in integrating mode; otherwise the line is ignored
        hold_now = ctrl_q[pbc_pkg::CTRL_INTEG] && sync2_q[3];
    end

    // reading the status word is the result query
    assign query = reg_rd && (reg_addr == pbc_pkg::ADDR_STATUS);
    assign start = ((st_q == pbc_pkg::ST_IDLE) && ctrl_q[pbc_pkg::CTRL_RUN])
        || ((st_q == pbc_pkg::ST_DONE) && query && ctrl_q[pbc_pkg::CTRL_RUN]);

    // the checking register relocks on every start and while restart is held in integrating mode
    assign lf.sel = sel;
    assign lf.rx_bit = rx_raw;
    assign lf.shift = bit_stb && valid && !hold_now && (st_q == pbc_pkg::ST_RUN);
    assign lf.clear = start || (st_q != pbc_pkg::ST_RUN) || (bit_stb && hold_now);

    // a break without integration just shows up as errors; lock is kept
    assign cnt_en = lf.shift && lf.locked;
    assign bit_nx = bit_cnt_q + 32'h0000_0001;
    assign err_nx = err_cnt_q + {31'h0000_0000, lf.miss};
    // both limits watched together; reaching or passing either one ends it
    assign end_tot = cnt_en && (bit_nx >= tot_lim_q);
    assign end_err = cnt_en && lf.miss && (err_nx >= err_lim_q);
    // at or above 3/8 error rate the start position was wrong, not the channel
    assign slip_now = err_nx >= ({2'h0, bit_nx[31:2]} + {3'h0, bit_nx[31:3]});

    // measurement sequencing: waits in done until the result is read
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= pbc_pkg::ST_IDLE;
        end else begin
            case (st_q)
                pbc_pkg::ST_IDLE: begin
                    if (ctrl_q[pbc_pkg::CTRL_RUN]) begin
                        st_q <= pbc_pkg::ST_RUN;
                    end
                end
                pbc_pkg::ST_RUN: begin
                    if (!ctrl_q[pbc_pkg::CTRL_RUN]) begin
                        st_q <= pbc_pkg::ST_IDLE;
                    end else if (end_tot || end_err) begin
                        st_q <= pbc_pkg::ST_DONE;
                    end
                end
                pbc_pkg::ST_DONE: begin
                    if (query) begin
                        // a discarded result is simply rerun from here
                        st_q <= ctrl_q[pbc_pkg::CTRL_RUN] ? pbc_pkg::ST_RUN : pbc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    st_q <= pbc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // 32-bit counts; restart intervals add up, only a new measurement clears
    always_ff @(posedge core_clk) begin
        if (reset || start) begin
            bit_cnt_q <= 32'h0000_0000;
            err_cnt_q <= 32'h0000_0000;
        end else if (cnt_en) begin
            bit_cnt_q <= bit_nx;
            err_cnt_q <= err_nx;
        end
    end

    // which criterion ended it, plus the slip verdict; start never meets a set
    always_ff @(posedge core_clk) begin
        if (reset || start) begin
            by_tot_q <= 1'h0;
            by_err_q <= 1'h0;
            slip_q <= 1'h0;
        end else if ((st_q == pbc_pkg::ST_RUN) && (end_tot || end_err)) begin
            by_tot_q <= end_tot;
            by_err_q <= end_err;
            slip_q <= slip_now;
        end
    end

    // software-written configuration and limits
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_q <= pbc_pkg::CTRL_RESET;
            tot_lim_q <= pbc_pkg::TOT_LIM_RESET;
            err_lim_q <= pbc_pkg::ERR_LIM_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                pbc_pkg::ADDR_CTRL: ctrl_q <= reg_wdata[pbc_pkg::CTRL_W-1:0];
                pbc_pkg::ADDR_TOT_LIM: tot_lim_q <= reg_wdata;
                pbc_pkg::ADDR_ERR_LIM: err_lim_q <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // status word as seen by a query
    always_comb begin
        status = 32'h0000_0000;
        status[pbc_pkg::STS_DONE] = st_q == pbc_pkg::ST_DONE;
        status[pbc_pkg::STS_BY_TOT] = by_tot_q;
        status[pbc_pkg::STS_BY_ERR] = by_err_q;
        status[pbc_pkg::STS_LOCKED] = lf.locked;
        status[pbc_pkg::STS_CLK_ACT] = act[0];
        status[pbc_pkg::STS_DATA_ACT] = act[1];
        status[pbc_pkg::STS_SLIP] = slip_q;
    end

    // read data only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge core_clk) begin
        if (reset || !reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            case (reg_addr)
                pbc_pkg::ADDR_CTRL: reg_rdata <= {23'h000000, ctrl_q};
                pbc_pkg::ADDR_TOT_LIM: reg_rdata <= tot_lim_q;
                pbc_pkg::ADDR_ERR_LIM: reg_rdata <= err_lim_q;
                pbc_pkg::ADDR_BIT_CNT: reg_rdata <= bit_cnt_q;
                pbc_pkg::ADDR_ERR_CNT: reg_rdata <= err_cnt_q;
                pbc_pkg::ADDR_STATUS: reg_rdata <= status;
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_end_total;
        st_q == pbc_pkg::ST_RUN && ctrl_q[pbc_pkg::CTRL_RUN] && cnt_en && bit_nx >= tot_lim_q
            |=> st_q == pbc_pkg::ST_DONE && by_tot_q;
    endproperty
    a_end_total: assert property (p_end_total) else $error("total limit did not end run");

    property p_end_error;
        st_q == pbc_pkg::ST_RUN && ctrl_q[pbc_pkg::CTRL_RUN] && cnt_en && lf.miss && err_nx >= err_lim_q
            |=> st_q == pbc_pkg::ST_DONE && by_err_q;
    endproperty
    a_end_error: assert property (p_end_error) else $error("error limit did not end run");

    property p_wait_query;
        st_q == pbc_pkg::ST_DONE && !query |=> st_q == pbc_pkg::ST_DONE && $stable(bit_cnt_q);
    endproperty
    a_wait_query: assert property (p_wait_query) else $error("restarted without query");

    property p_gate_excludes;
        bit_stb && !valid && !start |=> $stable(bit_cnt_q) && $stable(err_cnt_q);
    endproperty
    a_gate_excludes: assert property (p_gate_excludes) else $error("gated bit was counted");

    property p_restart_holds;
        bit_stb && hold_now ##1 st_q == pbc_pkg::ST_RUN |-> !lf.locked;
    endproperty
    a_restart_holds: assert property (p_restart_holds) else $error("lock kept under restart");

    property p_accumulate;
        st_q == pbc_pkg::ST_RUN && !start |=> bit_cnt_q >= $past(bit_cnt_q) && err_cnt_q >= $past(err_cnt_q);
    endproperty
    a_accumulate: assert property (p_accumulate) else $error("count dropped inside a run");

    property p_query_reports;
        query && st_q == pbc_pkg::ST_DONE |=> reg_rdata[pbc_pkg::STS_DONE]
            && (reg_rdata[pbc_pkg::STS_BY_TOT] || reg_rdata[pbc_pkg::STS_BY_ERR]);
    endproperty
    a_query_reports: assert property (p_query_reports) else $error("query lacks end criterion");

    property p_clk_activity;
        sync2_q[0] != line_d_q[0] |=> act[0] [*8];
    endproperty
    a_clk_activity: assert property (p_clk_activity) else $error("clock toggle not shown");

    property p_one_bit_per_edge;
        cnt_en |=> bit_cnt_q == $past(bit_cnt_q) + 32'h0000_0001 || $past(start);
    endproperty
    a_one_bit_per_edge: assert property (p_one_bit_per_edge) else $error("bit count not one per edge");

    // a mismatch against the prediction adds exactly one error
    property p_miss_counts;
        cnt_en && (rx_raw != lf.pred_bit)
            |=> err_cnt_q == $past(err_cnt_q) + 32'h0000_0001;
    endproperty
    a_miss_counts: assert property (p_miss_counts) else $error("mismatch not counted");

    // fill bits only load the register
    property p_fill_uncounted;
        lf.shift && !lf.locked
            |=> $stable(bit_cnt_q) && $stable(err_cnt_q);
    endproperty
    a_fill_uncounted: assert property (p_fill_uncounted) else $error("fill bit was counted");

    // outside a run the result stays frozen until a new start
    property p_idle_frozen;
        st_q != pbc_pkg::ST_RUN && !start
            |=> $stable(bit_cnt_q) && $stable(err_cnt_q);
    endproperty
    a_idle_frozen: assert property (p_idle_frozen) else $error("count moved outside a run");

    // a new measurement never inherits the old verdict
    property p_start_clears;
        start |=> bit_cnt_q == 32'h0000_0000 && err_cnt_q == 32'h0000_0000
            && !by_tot_q && !by_err_q && !slip_q;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start kept old result");

    // data line activity, same window as the clock line
    property p_data_activity;
        sync2_q[1] != line_d_q[1]
            |=> act[1] [*8];
    endproperty
    a_data_activity: assert property (p_data_activity) else $error("data toggle not shown");

    // without integration the restart line must not stall checking
    property p_restart_ignored;
        bit_stb && valid && !ctrl_q[pbc_pkg::CTRL_INTEG] && st_q == pbc_pkg::ST_RUN
            |-> lf.shift;
    endproperty
    a_restart_ignored: assert property (p_restart_ignored) else $error("restart not ignored");

    // a half-error result is marked so the query reruns it
    property p_slip_flag;
        st_q == pbc_pkg::ST_RUN && (end_tot || end_err) && slip_now
            |=> slip_q;
    endproperty
    a_slip_flag: assert property (p_slip_flag) else $error("slip not flagged");
endmodule

//--- testbench/pbc_prbs_source.sv
`timescale 1ns/100ps
// stands in for the device under test: returns a prbs stream with its bit clock, gate and restart
module pbc_prbs_source (
    output logic bit_clk,
    output logic data,
    output logic gate,
    output logic restart
);
    logic [22:0] lfsr = 23'h000001;
    logic [22:0] taps = 23'h000108;
    logic inv = 1'b0;
    logic act = 1'b1;
    logic line_inv = 1'b0;
    logic gate_pol = 1'b1;

    // lines settle at time zero; the bit clock stands still between bursts
    initial begin
        bit_clk = 1'b0;
        data = 1'b0;
        gate = 1'b1;
        restart = 1'b0;
    end

    // polynomial per selection code, tap k at mask bit k-1
    task automatic setup(input logic [2:0] sel, input logic rise, input logic winv, input logic gpol);
        case (sel)
            pbc_pkg::PRBS_DEGREE11: taps = 23'h000402;
            pbc_pkg::PRBS_DEGREE15: taps = 23'h004001;
            pbc_pkg::PRBS_DEGREE16: taps = 23'h008016;
            pbc_pkg::PRBS_DEGREE20: taps = 23'h080004;
            pbc_pkg::PRBS_DEGREE21: taps = 23'h100002;
            pbc_pkg::PRBS_DEGREE23: taps = 23'h400010;
            default: taps = 23'h000108;
        endcase
        inv = (sel == pbc_pkg::PRBS_DEGREE15) || (sel == pbc_pkg::PRBS_DEGREE23);
        act = rise;
        line_inv = winv;
        gate_pol = gpol;
        bit_clk <= ~rise;
        gate <= gpol;
    endtask

    // a jump in the sequence, as at a memory wrap-around
    task automatic reseed(input logic [22:0] s);
        lfsr = s;
    endtask

    // lines change half a period before each active edge so they are stable around it
    task automatic send(input int n, input int flip_lo, input int flip_hi, input int gate_lo,
        input int gate_hi, input logic rst);
        logic ok;
        for (int i = 0; i < n; i++) begin
            ok = rst || i < gate_lo || i >= gate_hi;
            if (ok && !rst) begin
                lfsr = {lfsr[21:0], ^(lfsr & taps)};
                data <= lfsr[0] ^ inv ^ line_inv ^ (i >= flip_lo && i < flip_hi);
            end else begin
                data <= ~data; // inserted filler does not advance the sequence
            end
            gate <= ok ? gate_pol : ~gate_pol;
            restart <= rst;
            #160 bit_clk <= act;
            #160 bit_clk <= ~act;
        end
        restart <= 1'b0;
        data <= ~data; // a released line never keeps showing the last bit
        #320;
    endtask
endmodule

//--- testbench/pbc_checker_bench.sv
`timescale 1ns/100ps
// each test programs the checker, feeds bits from the source model and reads the results back
module pbc_checker_bench;
    localparam int LIMIT = 40000; // about five times the cycles the tests need
    localparam int NONE = 100000;
    localparam logic [31:0] RUN = 32'h1 << pbc_pkg::CTRL_RUN;
    localparam logic [31:0] RISE = 32'h1 << pbc_pkg::CTRL_CLK_POL;
    localparam logic [31:0] DINV = 32'h1 << pbc_pkg::CTRL_DATA_INV;
    localparam logic [31:0] GEN = 32'h1 << pbc_pkg::CTRL_GATE_EN;
    localparam logic [31:0] GPOL = 32'h1 << pbc_pkg::CTRL_GATE_POL;
    localparam logic [31:0] INTEG = 32'h1 << pbc_pkg::CTRL_INTEG;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic bit_clk;
    logic data;
    logic gate;
    logic restart;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rd;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int deg [8] = '{9, 11, 15, 16, 20, 21, 23, 9};

    pbc_checker i_pbc_checker (.core_clk(core_clk), .reset(reset), .bit_clk_in(bit_clk), .data_in(data),
        .data_valid_gate(gate), .measure_restart_in(restart), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    pbc_prbs_source i_pbc_prbs_source (.bit_clk(bit_clk), .data(data), .gate(gate), .restart(restart));

    // 25 MHz core clock
    always #20 core_clk = ~core_clk;

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // a hung handshake or stuck source must not run forever
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches = mismatches + 1;
            end_of_test();
        end
    end

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
        reg_read(a, rd);
        chk(name, exp, rd);
    endtask

    // a status read is also the result query, so a finished measurement restarts here
    task automatic chk_sts(input string name, input logic [31:0] mask, input logic [31:0] exp);
        reg_read(pbc_pkg::ADDR_STATUS, rd);
        chk(name, exp, rd & mask);
    endtask

    task automatic chk_counts(input logic [31:0] bits, input logic [31:0] errs);
        chk_reg("bit count", pbc_pkg::ADDR_BIT_CNT, bits);
        chk_reg("error count", pbc_pkg::ADDR_ERR_CNT, errs);
    endtask

    // back to idle, set limits, match the source to the setting, then run
    task automatic start(input logic [31:0] c, input logic [31:0] tot, input logic [31:0] err);
        reg_write(pbc_pkg::ADDR_CTRL, c);
        reg_write(pbc_pkg::ADDR_TOT_LIM, tot);
        reg_write(pbc_pkg::ADDR_ERR_LIM, err);
        i_pbc_prbs_source.setup(c[2:0], c[pbc_pkg::CTRL_CLK_POL], c[pbc_pkg::CTRL_DATA_INV],
            c[pbc_pkg::CTRL_GATE_POL]);
        reg_write(pbc_pkg::ADDR_CTRL, c | RUN);
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        chk_reg("ctrl reset", pbc_pkg::ADDR_CTRL, 32'h0000_0008);
        chk_reg("total limit reset", pbc_pkg::ADDR_TOT_LIM, 32'h000F_4240);
        chk_reg("error limit reset", pbc_pkg::ADDR_ERR_LIM, 32'h0000_0064);
        reg_write(pbc_pkg::ADDR_BIT_CNT, 32'h0000_1234);
        chk_counts(32'h0, 32'h0);
        chk_reg("unmapped", 8'h18, 32'h0);
        chk_sts("quiet lines", 32'h30, 32'h0);
        // every polynomial: n bits fill the register, then 40 clean bits are counted
        for (int s = 0; s < 8; s++) begin
            start(32'(s) | RISE, 32'h0000_FFFF, 32'h0000_FFFF);
            i_pbc_prbs_source.send(deg[s] + 40, NONE, NONE, NONE, NONE, 1'b0);
            chk_counts(32'h28, 32'h0);
        end
        chk_sts("lock and activity", 32'h38, 32'h38);
        repeat (300) @(posedge core_clk);
        chk_sts("activity lapsed", 32'h30, 32'h0);
        // total limit with one error; later bits wait for the query
        start(RISE, 32'h0000_001E, 32'h0000_FFFF);
        i_pbc_prbs_source.send(60, 20, 21, NONE, NONE, 1'b0);
        chk_counts(32'h1E, 32'h1);
        chk_sts("end by total", 32'h7, 32'h3);
        i_pbc_prbs_source.send(19, NONE, NONE, NONE, NONE, 1'b0);
        chk_counts(32'hA, 32'h0);
        // error limit
        start(RISE, 32'h0000_FFFF, 32'h0000_0002);
        i_pbc_prbs_source.send(40, 15, 17, NONE, NONE, 1'b0);
        chk_counts(32'h8, 32'h2);
        chk_sts("end by errors", 32'h7, 32'h5);
        // an error while filling gives about half errors, flagged and rerun on the query
        start(RISE, 32'h0000_0040, 32'h0000_FFFF);
        i_pbc_prbs_source.send(80, 3, 4, NONE, NONE, 1'b0);
        chk_sts("slip flag", 32'h43, 32'h43);
        i_pbc_prbs_source.send(19, NONE, NONE, NONE, NONE, 1'b0);
        chk_counts(32'hA, 32'h0);
        // gated bits are skipped under both gate polarities
        for (int p = 0; p < 2; p++) begin
            start(RISE | GEN | (p != 0 ? GPOL : 32'h0), 32'h0000_FFFF, 32'h0000_FFFF);
            i_pbc_prbs_source.send(60, NONE, NONE, 15, 25, 1'b0);
            chk_counts(32'h29, 32'h0);
        end
        // falling active edge with an inverted data line
        start(32'(pbc_pkg::PRBS_DEGREE11) | DINV, 32'h0000_FFFF, 32'h0000_FFFF);
        i_pbc_prbs_source.send(51, NONE, NONE, NONE, NONE, 1'b0);
        chk_counts(32'h28, 32'h0);
        // a break in the sequence without integration shows up as errors
        start(RISE, 32'h0000_FFFF, 32'h0000_FFFF);
        i_pbc_prbs_source.send(29, NONE, NONE, NONE, NONE, 1'b0);
        i_pbc_prbs_source.reseed(23'h05A5A5);
        i_pbc_prbs_source.send(20, NONE, NONE, NONE, NONE, 1'b0);
        reg_read(pbc_pkg::ADDR_ERR_CNT, rd);
        chk("errors after break", 32'h1, {31'h0, rd > 32'h0});
        // integration: a restart pulse at the break keeps counting clean across intervals
        start(RISE | INTEG, 32'h0000_FFFF, 32'h0000_FFFF);
        i_pbc_prbs_source.send(29, NONE, NONE, NONE, NONE, 1'b0);
        i_pbc_prbs_source.reseed(23'h05A5A5);
        i_pbc_prbs_source.send(2, NONE, NONE, NONE, NONE, 1'b1);
        i_pbc_prbs_source.send(29, NONE, NONE, NONE, NONE, 1'b0);
        chk_counts(32'h28, 32'h0);
        end_of_test();
    end
endmodule
